/* common/adc_cfg_defs.vh */
// constants for the serial configuration port
`ifndef ADC_CFG_DEFS_VH
`define ADC_CFG_DEFS_VH
`define WORD_BITS 16
`define ADDR_BITS 7
`define DATA_BITS 8
`define REG_COUNT 2
`define OFF_SOFT_RESET_CONTROL 7'h00
`define OFF_FORMAT_AND_POWER_DOWN 7'h01
`define SOFT_RESET_BIT 7
`define FMT_RESET_VALUE 8'h00
`define FMT_DCS_DISABLE_BIT 7
`define FMT_SCRAMBLE_BIT 6
`define FMT_SIGNED_BIT 5
`define FMT_SLEEP_BIT 4
`define FMT_NAP2_BIT 3
`define FMT_NAP1_BIT 0
`define FMT_USED_MASK 8'hf9
`define RESET_SLEEP_NS 100
`define CLK_PERIOD_NS 10
`define RESET_SLEEP_CYCLES ((`RESET_SLEEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_WIDTH 16
`endif

/* rtl/cfg_reg_store.v */
// small register store with registered read data
`timescale 1ns/1ps
`default_nettype none
module cfg_reg_store #(
	parameter AW = 1,
	parameter DW = 8,
	parameter DEPTH = 2,
	parameter [7:0] RESET_VALUE = 8'h00
) (
	// clock and reset
	input wire i_mclk,
	input wire i_rst_n,
	input wire i_ce,
	// write port
	input wire i_clear,
	input wire i_wr,
	input wire [AW-1:0] i_waddr,
	input wire [DW-1:0] i_wdata,
	// read port
	input wire [AW-1:0] i_raddr,
	output reg [DW-1:0] o_rdata,
	// all words flat for the mode logic
	output wire [DW*DEPTH-1:0] o_flat
);
	reg [DW-1:0] mem_reg [0:DEPTH-1];
	integer k;
	genvar g;

	// clear takes priority, it models the software reset
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (k = 0; k < DEPTH; k = k + 1) begin
				mem_reg[k] <= RESET_VALUE[DW-1:0];
			end
			o_rdata <= {DW{1'b0}};
		end else if (i_ce) begin
			if (i_clear) begin
				for (k = 0; k < DEPTH; k = k + 1) begin
					mem_reg[k] <= RESET_VALUE[DW-1:0];
				end
			end else if (i_wr) begin
				mem_reg[i_waddr] <= i_wdata;
			end
			o_rdata <= mem_reg[i_raddr];
		end
	end

	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : flat_gen
			assign o_flat[g*DW +: DW] = mem_reg[g];
		end
	endgenerate
endmodule
`default_nettype wire

/* rtl/adc_serial_config_port.v */
// serial configuration port with format and power-down control
// Overview of operation
// - serial port works only while the port style select pin is low
// - every access is one sixteen-bit command word
// - chip select falling starts a new command word
// - input bits sampled on the first sixteen rising serial clock edges
// - rising edges past the sixteenth are ignored
// - chip select rising ends the transfer
// - word order: direction bit, seven address bits, eight data bits, msb first
// - direction zero writes the data, bits two and one cleared, into the addressed register
// - direction one returns the addressed register on the serial output
// - reads leave the register unchanged and ignore serial input
// - serial output is open drain, driven low only
// - software reset clears all mode registers and briefly forces sleep
// - reset bit clears itself after its write completes
// - reset register is write-only, reads return all ones
// - power-down bits: sleep, channel two nap, channel one nap
// - sleep disables both channels whatever the nap bits hold
// - scramble xors the lsb into all other data bits
// - signed select gives two's complement, else offset binary
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_defs.vh"
module adc_serial_config_port #(
	parameter SAMPLE_W = `SAMPLE_WIDTH
) (
	// clock, reset, enable
	input wire i_mclk,
	input wire i_rst_n,
	input wire i_ce,
	// configuration pins
	input wire i_port_style_select,
	input wire i_cs_n,
	input wire i_sck,
	input wire i_sdi,
	output reg o_sdo_out,
	output reg o_sdo_oe_n,
	// converter data path
	input wire [SAMPLE_W-1:0] i_ch1_sample,
	input wire [SAMPLE_W-1:0] i_ch2_sample,
	output reg [SAMPLE_W-1:0] o_ch1_data,
	output reg [SAMPLE_W-1:0] o_ch2_data,
	// mode controls
	output reg o_duty_stabilizer_disable,
	output reg o_sleep,
	output reg o_ch1_nap,
	output reg o_ch2_nap,
	output reg o_xfer_active
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_SHIFT = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;
	// counts worked out as integers, then cut to the counter widths on purpose
	localparam integer SLEEP_CYCLES_INT = `RESET_SLEEP_CYCLES;
	localparam integer LAST_BIT_INT = `WORD_BITS - 1;
	localparam integer HEAD_BITS_INT = `WORD_BITS - `DATA_BITS;
	localparam [7:0] SLEEP_CYCLES = SLEEP_CYCLES_INT[7:0];
	localparam [4:0] LAST_BIT = LAST_BIT_INT[4:0];
	localparam [4:0] HEAD_BITS = HEAD_BITS_INT[4:0];

	// two flop synchronisers; stage one is read only by stage two
	reg [1:0] sel_sync_reg, cs_sync_reg, sck_sync_reg, sdi_sync_reg;
	reg sck_prev_reg;
	reg [2:0] state_reg;
	reg [4:0] bit_cnt_reg;
	reg [15:0] shift_reg;
	reg [7:0] rd_shift_reg;
	reg is_read_reg;
	reg [7:0] sleep_cnt_reg;
	reg store_wr, store_clr;
	wire serial_mode = ~sel_sync_reg[1];
	wire cs_low = cs_sync_reg[1];
	wire sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
	wire sck_fall = ~sck_sync_reg[1] & sck_prev_reg;
	wire [15:0] word_next = {shift_reg[14:0], sdi_sync_reg[1]};
	wire [7:0] store_rdata;
	wire [15:0] store_flat;
	wire [7:0] fmt = store_flat[15:8];

	// mode select pin; resets to parallel so no frame opens while it settles
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sel_sync_reg <= 2'h3;
		end else if (i_ce) begin
			sel_sync_reg <= {sel_sync_reg[0], i_port_style_select};
		end
	end

	// chip select, kept active high so reset reads as deselected
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_sync_reg <= 2'h0;
		end else if (i_ce) begin
			cs_sync_reg <= {cs_sync_reg[0], ~i_cs_n};
		end
	end

	// serial clock; two flops keep a raw pin edge off the state logic
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sck_sync_reg <= 2'h0;
		end else if (i_ce) begin
			sck_sync_reg <= {sck_sync_reg[0], i_sck};
		end
	end

	// serial data, same delay as the clock so each bit meets its edge
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sdi_sync_reg <= 2'h0;
		end else if (i_ce) begin
			sdi_sync_reg <= {sdi_sync_reg[0], i_sdi};
		end
	end

	// clock history for edge finding; reset low matches the idle level
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sck_prev_reg <= 1'b0;
		end else if (i_ce) begin
			sck_prev_reg <= sck_sync_reg[1];
		end
	end

	// sign and scramble applied to a sample word
	function [SAMPLE_W-1:0] fmt_sample;
		input [SAMPLE_W-1:0] s;
		input signed_sel;
		input scramble;
		reg [SAMPLE_W-1:0] t;
		begin
			t = s;
			if (signed_sel) begin
				t[SAMPLE_W-1] = ~t[SAMPLE_W-1];
			end
			if (scramble) begin
				t[SAMPLE_W-1:1] = t[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){t[0]}};
			end
			fmt_sample = t;
		end
	endfunction

	// register select decode, shared by write commit and read back
	function is_fmt_addr;
		input [6:0] a;
		begin
			is_fmt_addr = (a == `OFF_FORMAT_AND_POWER_DOWN);
		end
	endfunction

	function is_reset_addr;
		input [6:0] a;
		begin
			is_reset_addr = (a == `OFF_SOFT_RESET_CONTROL);
		end
	endfunction

	// frame state machine
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
		end else if (i_ce) begin
			case (state_reg)
				ST_IDLE: begin
					if (serial_mode && cs_low) begin
						state_reg <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (!cs_low || !serial_mode) begin
						state_reg <= ST_IDLE;
					end else if (sck_rise && bit_cnt_reg == LAST_BIT) begin
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: begin
					// extra edges ignored until chip select rises
					if (!cs_low || !serial_mode) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// bit counter and input shifter; cleared while idle so bits of a
	// cut frame never leak into the next command
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bit_cnt_reg <= 5'h00;
			shift_reg <= 16'h0000;
			is_read_reg <= 1'b0;
		end else if (i_ce) begin
			if (state_reg == ST_IDLE) begin
				bit_cnt_reg <= 5'h00;
				shift_reg <= 16'h0000;
				is_read_reg <= 1'b0;
			end else if (state_reg == ST_SHIFT && cs_low && serial_mode && sck_rise) begin
				shift_reg <= word_next;
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
				if (bit_cnt_reg == 5'h00) begin
					is_read_reg <= sdi_sync_reg[1];
				end
			end
		end
	end

	// write commit and soft reset decode
	always @* begin
		store_wr = 1'b0;
		store_clr = 1'b0;
		if (state_reg == ST_SHIFT && cs_low && serial_mode && sck_rise
				&& bit_cnt_reg == LAST_BIT && !is_read_reg) begin
			if (is_reset_addr(word_next[14:8])) begin
				// reset bit is never stored; reads of this address return all ones
				store_clr = word_next[`SOFT_RESET_BIT];
			end else if (is_fmt_addr(word_next[14:8])) begin
				store_wr = 1'b1;
			end
		end
	end

	cfg_reg_store #(
		.AW(1),
		.DW(8),
		.DEPTH(`REG_COUNT),
		.RESET_VALUE(`FMT_RESET_VALUE)
	) u_store (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_clear(store_clr),
		.i_wr(store_wr),
		.i_waddr(word_next[8]),
		.i_wdata(word_next[7:0] & `FMT_USED_MASK),
		.i_raddr(shift_reg[0]),
		.o_rdata(store_rdata),
		.o_flat(store_flat)
	);

	// open drain: the data line only ever pulls low, the enable carries the bit
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sdo_out <= 1'b0;
		end else if (i_ce) begin
			o_sdo_out <= 1'b0;
		end
	end

	// read back on falling edges, msb first, during the data byte
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_shift_reg <= 8'h00;
			o_sdo_oe_n <= 1'b1;
		end else if (i_ce) begin
			if (state_reg != ST_SHIFT || !cs_low) begin
				o_sdo_oe_n <= 1'b1;
			end else if (sck_fall && bit_cnt_reg == HEAD_BITS && is_read_reg) begin
				// address in shift_reg[6:0]; other addresses read as released ones
				if (is_fmt_addr(shift_reg[6:0])) begin
					rd_shift_reg <= {store_rdata[6:0], 1'b0};
					o_sdo_oe_n <= store_rdata[7];
				end else begin
					rd_shift_reg <= 8'hff;
					o_sdo_oe_n <= 1'b1;
				end
			end else if (sck_fall && bit_cnt_reg > HEAD_BITS && is_read_reg) begin
				o_sdo_oe_n <= rd_shift_reg[7];
				rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
			end
		end
	end

	// brief sleep after a software reset; loaded one short because the
	// strobe cycle itself already forces sleep
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sleep_cnt_reg <= 8'h00;
		end else if (i_ce) begin
			if (store_clr) begin
				sleep_cnt_reg <= SLEEP_CYCLES - 8'h01;
			end else if (sleep_cnt_reg != 8'h00) begin
				sleep_cnt_reg <= sleep_cnt_reg - 8'h01;
			end
		end
	end

	// sleep request from the register or the reset pulse
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sleep <= 1'b0;
		end else if (i_ce) begin
			o_sleep <= fmt[`FMT_SLEEP_BIT] | (sleep_cnt_reg != 8'h00) | store_clr;
		end
	end

	// channel naps; masked by the sleep bit only, so a nap showing before a software reset stays up with o_sleep for one cycle
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ch1_nap <= 1'b0;
			o_ch2_nap <= 1'b0;
		end else if (i_ce) begin
			o_ch1_nap <= fmt[`FMT_NAP1_BIT] & ~fmt[`FMT_SLEEP_BIT];
			o_ch2_nap <= fmt[`FMT_NAP2_BIT] & ~fmt[`FMT_SLEEP_BIT];
		end
	end

	// clock duty stabiliser control
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_duty_stabilizer_disable <= 1'b0;
		end else if (i_ce) begin
			o_duty_stabilizer_disable <= fmt[`FMT_DCS_DISABLE_BIT];
		end
	end

	// frame activity flag
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_xfer_active <= 1'b0;
		end else if (i_ce) begin
			o_xfer_active <= (state_reg != ST_IDLE);
		end
	end

	// formatted samples, one cycle behind the raw inputs
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ch1_data <= {SAMPLE_W{1'b0}};
			o_ch2_data <= {SAMPLE_W{1'b0}};
		end else if (i_ce) begin
			o_ch1_data <= fmt_sample(i_ch1_sample, fmt[`FMT_SIGNED_BIT], fmt[`FMT_SCRAMBLE_BIT]);
			o_ch2_data <= fmt_sample(i_ch2_sample, fmt[`FMT_SIGNED_BIT], fmt[`FMT_SCRAMBLE_BIT]);
		end
	end
endmodule
`default_nettype wire

/* sim/adc_cfg_sva.sv */
// pin-level assertions for the configuration port
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_sva (
	// watched ports
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_port_style_select,
	input wire logic i_cs_n,
	input wire logic o_sdo_out,
	input wire logic o_sdo_oe_n,
	input wire logic o_duty_stabilizer_disable,
	input wire logic o_ch1_nap,
	input wire logic o_ch2_nap,
	input wire logic o_sleep,
	input wire logic o_xfer_active
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// the pin may only ever be pulled low
	a_sdo_low_only: assert property (!o_sdo_out)
		else $error("sdo driven high");
	a_release_idle: assert property (i_cs_n [*8] |-> o_sdo_oe_n)
		else $error("sdo held outside a frame");
	a_drive_in_frame: assert property ($fell(o_sdo_oe_n) |-> o_xfer_active && $past(!i_cs_n, 3))
		else $error("sdo driven with no frame");
	a_parallel_idle: assert property (i_port_style_select [*8] |-> !o_xfer_active)
		else $error("frame opened in parallel mode");
	a_frame_start: assert property ((!i_cs_n && !i_port_style_select) [*6] |-> o_xfer_active)
		else $error("frame not opened");
	a_frame_end: assert property (i_cs_n [*6] |-> !o_xfer_active)
		else $error("frame not closed");
	// mode bits only move when a frame commits
	a_modes_hold: assert property (i_cs_n [*8] |-> $stable({o_ch1_nap, o_ch2_nap, o_duty_stabilizer_disable}))
		else $error("mode changed between frames");
	a_ce_freeze: assert property (!i_ce |=> $stable({o_sleep, o_xfer_active, o_sdo_oe_n}))
		else $error("state moved with enable low");
endmodule
bind adc_serial_config_port adc_cfg_sva u_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
	.i_port_style_select(i_port_style_select), .i_cs_n(i_cs_n), .o_sdo_out(o_sdo_out),
	.o_sdo_oe_n(o_sdo_oe_n), .o_duty_stabilizer_disable(o_duty_stabilizer_disable),
	.o_ch1_nap(o_ch1_nap), .o_ch2_nap(o_ch2_nap), .o_sleep(o_sleep),
	.o_xfer_active(o_xfer_active));
`default_nettype wire

/* sim/cfg_host_model.sv */
// serial bus master model sending command frames
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
	// clock and pins
	input wire logic i_mclk,
	input wire logic i_sdo,
	output logic o_cs_n,
	output logic o_sck,
	output logic o_sdi
);
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_sdi = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	// n rises in one frame; bits past sixteen are ones, read bits taken before rises nine to sixteen
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		o_cs_n = 1'b0;
		tick(8);
		for (int i = 0; i < n; i++) begin
			o_sck = 1'b0;
			o_sdi = (i < 16) ? w[15 - i] : 1'b1;
			tick(8);
			if (i >= 8 && i < 16) rd = {rd[6:0], i_sdo};
			o_sck = 1'b1;
			tick(8);
		end
		o_sck = 1'b0;
		o_sdi = ~o_sdi; // no stale level after the frame
		tick(8);
		o_cs_n = 1'b1;
		tick(8);
	endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the configuration port
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_defs.vh"
module tb_top;
	logic i_mclk, i_rst_n, i_ce, sel, cs_n, sck, sdi, sdo_out, sdo_oe_n, sdo;
	logic dcs, slp, nap1, nap2, act;
	logic [15:0] s1, s2, d1, d2;
	logic [7:0] rd;
	int errors, n_compared, sleep_cnt;
	assign sdo = sdo_oe_n ? 1'b1 : sdo_out; // pull-up when released
	cfg_host_model host (.i_mclk(i_mclk), .i_sdo(sdo), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi));
	adc_serial_config_port dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_port_style_select(sel), .i_cs_n(cs_n), .i_sck(sck), .i_sdi(sdi),
		.o_sdo_out(sdo_out), .o_sdo_oe_n(sdo_oe_n), .i_ch1_sample(s1), .i_ch2_sample(s2),
		.o_ch1_data(d1), .o_ch2_data(d2), .o_duty_stabilizer_disable(dcs), .o_sleep(slp),
		.o_ch1_nap(nap1), .o_ch2_nap(nap2), .o_xfer_active(act));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	always @(negedge i_mclk) if (slp === 1'b1) sleep_cnt++;
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
		host.xfer({1'b0, a, d}, n, rd);
	endtask
	// read with zeros on sdi, so a read taken as a write would show
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		host.xfer({1'b1, a, 8'h00}, 16, rd);
		chk("read", {8'h00, exp}, {8'h00, rd});
	endtask
	// sign flip of the msb first, then lsb folded into the rest
	function automatic logic [15:0] fmt(input logic [15:0] x);
		fmt = {~x[15], x[14:0]};
		fmt = fmt ^ {{15{fmt[0]}}, 1'b0};
	endfunction
	task automatic stop_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		stop_test;
	end
	initial begin
		errors = 0;
		n_compared = 0;
		sleep_cnt = 0;
		{i_rst_n, sel, i_ce, s1, s2} = {3'b001, 16'h8003, 16'h1234};
		host.tick(4);
		i_rst_n = 1'b1;
		host.tick(3);
		chk("oe_n idle", 16'h1, {15'h0, sdo_oe_n});
		wr(7'h00, 8'h80);
		chk("reset sleep", `RESET_SLEEP_CYCLES, sleep_cnt[15:0]);
		chk("offset data", 16'h8003, d1);
		rd_chk(7'h01, 8'h00);
		wr(7'h01, 8'hff);
		chk("modes all", 16'hc, {12'h0, dcs, slp, nap2, nap1});
		rd_chk(7'h01, `FMT_USED_MASK);
		rd_chk(7'h01, `FMT_USED_MASK);
		wr(7'h01, 8'h09);
		chk("naps", 16'h3, {12'h0, dcs, slp, nap2, nap1});
		wr(7'h01, 8'h60, 20);
		host.tick(100);
		chk("ch1 data", fmt(s1), d1);
		chk("ch2 data", fmt(s2), d2);
		rd_chk(7'h01, 8'h60);
		host.xfer(16'h0110, 8, rd);
		sel = 1'b1;
		host.tick(4);
		wr(7'h01, 8'h10);
		sel = 1'b0;
		i_ce = 1'b0;
		host.tick(5);
		i_ce = 1'b1;
		host.tick(4);
		rd_chk(7'h01, 8'h60);
		wr(7'h00, 8'h80);
		rd_chk(7'h01, 8'h00);
		stop_test;
	end
endmodule
`default_nettype wire
